// *** design/asr_pkg.sv ***
package asr_pkg;
    localparam int unsigned ELEM_STAGES   = 32;
    localparam int unsigned HALF_STAGES   = 16;
    localparam int unsigned STAGE_AW      = 5;
    localparam int unsigned HALF_AW       = 4;
    localparam int unsigned NUM_ELEM      = 4;
    localparam int unsigned ELEM_SEL_W    = 2;
    localparam int unsigned TAP_AW        = STAGE_AW + ELEM_SEL_W;
    localparam int unsigned CHAIN_STAGES  = ELEM_STAGES * NUM_ELEM;
    localparam int unsigned FILL_W        = 8;
    localparam int unsigned FIFO_W        = 2;
    localparam int unsigned FIFO_DEPTH    = 16;
    localparam logic [FILL_W-1:0] FILL_RST       = 8'h00;
    localparam logic [FILL_W-1:0] FILL_FULL      = 8'h80;
    localparam logic [FILL_W-1:0] FILL_HALF      = 8'h10;
    localparam logic              LUT_LSB_TIE    = 1'b1;
    localparam logic              READY_RST      = 1'b1;
endpackage

// *** design/asr_elem_if.sv ***
`timescale 1ns/1ns
interface asr_elem_if;
    logic                         shift_en;
    logic                         dual;
    logic                         ser_a;
    logic                         ser_b;
    logic [asr_pkg::STAGE_AW-1:0] addr;
    logic                         tap_a;
    logic                         tap_b;
    logic                         last;
    modport elem (input shift_en, input dual, input ser_a, input ser_b, input addr,
                  output tap_a, output tap_b, output last);
    modport ctl  (output shift_en, output dual, output ser_a, output ser_b, output addr,
                  input tap_a, input tap_b, input last);
endinterface

// *** design/asr_fifo.sv ***
`timescale 1ns/1ns
module asr_fifo #(
    parameter int unsigned W     = 2,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    input  wire logic         i_valid,
    output logic              o_ready,
    input  wire logic [W-1:0] i_data,
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic [W-1:0]      o_data
);
    import asr_pkg::*;
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW-1:0] rd_ptr_nxt;
    logic [W-1:0]  head_r;
    logic [W-1:0]  head_nxt;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic          ready_r;
    wire           push = i_valid && ready_r;
    wire           pop  = o_valid && i_ready;
    // occupancy after this edge
    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    assign o_ready = ready_r;
    assign o_valid = (cnt_r != '0);
    assign rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    // head word after this edge; a write into the head slot bypasses the memory
    assign head_nxt = (push && wr_ptr_r == rd_ptr_nxt) ? i_data : mem_r[rd_ptr_nxt];
    assign o_data  = head_r;
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= i_data;
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
            ready_r  <= READY_RST;
            head_r   <= '0;
        end else begin
            wr_ptr_r <= push ? wr_ptr_r + 1'b1 : wr_ptr_r;
            rd_ptr_r <= rd_ptr_nxt;
            head_r   <= head_nxt;
            cnt_r    <= cnt_nxt;
            ready_r  <= (cnt_nxt != CNT_FULL);
        end
    end
    AST_FIFO_FULL_REFUSE: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (cnt_r == CNT_FULL) |-> !o_ready)
        else $error("fifo ready while full");
    AST_FIFO_COUNT: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (push && !pop) |=> (cnt_r == $past(cnt_r) + 1'b1))
        else $error("fifo count missed a push");
endmodule

// *** design/asr_elem.sv ***
`timescale 1ns/1ns
module asr_elem (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    asr_elem_if.elem  e
);
    import asr_pkg::*;
    logic [ELEM_STAGES-1:0] stage_r = '0;
    logic [ELEM_STAGES-1:0] stage_nxt;
    logic [STAGE_AW:0]      lut_idx;
    logic [STAGE_AW-1:0]    sel_full;
    logic [STAGE_AW-1:0]    sel_lo;
    logic [STAGE_AW-1:0]    sel_hi;
    // two split halves or one 32 stage line
    assign stage_nxt = e.dual
        ? {stage_r[ELEM_STAGES-2:HALF_STAGES], e.ser_b, stage_r[HALF_STAGES-2:0], e.ser_a}
        : {stage_r[ELEM_STAGES-2:0], e.ser_a};
    // no reset on the stages, single edge write
    always_ff @(posedge i_clk) begin
        if (e.shift_en) begin
            stage_r <= stage_nxt;
        end
    end
    assign lut_idx  = {e.addr, LUT_LSB_TIE};
    assign sel_full = lut_idx[STAGE_AW:1];
    assign sel_lo   = {1'b0, e.addr[HALF_AW-1:0]};
    assign sel_hi   = {1'b1, e.addr[HALF_AW-1:0]};
    assign e.tap_a  = e.dual ? stage_r[sel_lo] : stage_r[sel_full];
    assign e.tap_b  = e.dual ? stage_r[sel_hi] : 1'b0;
    assign e.last   = stage_r[ELEM_STAGES-1];
    AST_SHIFT_IN: assert property (@(posedge i_clk) disable iff (!i_resetn)
        e.shift_en |=> stage_r[0] == $past(e.ser_a))
        else $error("stage zero did not load serial input");
    AST_SHIFT_MOVE: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (e.shift_en && !e.dual) |=> stage_r[ELEM_STAGES-1:1] == $past(stage_r[ELEM_STAGES-2:0]))
        else $error("stages did not move up by one");
    AST_NO_SHIFT_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !e.shift_en |=> $stable(stage_r))
        else $error("stages changed without a shift");
    AST_DUAL_HALF: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (e.shift_en && e.dual) |=> stage_r[HALF_STAGES] == $past(e.ser_b))
        else $error("upper half did not load its own input");
endmodule

// *** design/asr_top.sv ***
`timescale 1ns/1ns
// Behaviour
// - each element is a 32 stage shift line giving delays 1 to 32.
// - an enabled edge loads serial input to stage zero, others move up.
// - a 5 bit tap address picks which stage drives the tap output.
// - tap output follows the address combinationally, clock independent.
// - constant tap address N gives a fixed line of N plus one stages.
// - with constant address the tap changes only once per enabled shift.
// - cascade output always shows the last stage, updated each shift.
// - four elements chain cascade to serial input for up to 128 stages.
// - only the final element's cascade output is exposed.
// - stages have no set or reset; they change only by shifting.
// - the unused low lookup input is tied high.
// - an element may run as two independent 16 stage lines.
// - elements share one clock; writes happen on one edge with enable high.
module asr_top (
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_resetn,
    input  wire logic                         i_in_valid,
    input  wire logic [asr_pkg::FIFO_W-1:0]   i_in_data,
    input  wire logic                         i_ce_used,
    input  wire logic                         i_shift_ce,
    input  wire logic                         i_dual_mode,
    input  wire logic [asr_pkg::TAP_AW-1:0]   i_tap_addr,
    output logic                              o_in_ready,
    output logic                              o_tap_out,
    output logic                              o_tap_b_out,
    output logic                              o_tap_reg,
    output logic                              o_tap_b_reg,
    output logic                              o_cascade_out,
    output logic                              o_shift_pulse,
    output logic                              o_chain_primed
);
    import asr_pkg::*;

    // fill tracking states
    typedef enum logic [1:0] {
        ASR_EMPTY   = 2'b00,
        ASR_FILLING = 2'b01,
        ASR_PRIMED  = 2'b10
    } asr_fill_t;

    // segment muxes: low pair, high pair, then top
    function automatic logic seg_mux(
        input logic [NUM_ELEM-1:0]   taps,
        input logic [ELEM_SEL_W-1:0] sel
    );
        logic segment_mux_low;
        logic segment_mux_high;
        logic segment_mux_top;
        segment_mux_low  = sel[0] ? taps[1] : taps[0];
        segment_mux_high = sel[0] ? taps[3] : taps[2];
        segment_mux_top  = sel[1] ? segment_mux_high : segment_mux_low;
        return segment_mux_top;
    endfunction

    // stream buffer wires
    logic                  fifo_valid;
    logic [FIFO_W-1:0]     fifo_data;
    logic                  fifo_in_ready;

    // enable and shift decode
    logic                  ce_eff;
    logic                  shift_w;

    // per element taps
    logic [NUM_ELEM-1:0]   tap_a_vec;
    logic [NUM_ELEM-1:0]   tap_b_vec;
    logic [NUM_ELEM-1:0]   last_vec;

    // address split
    logic [STAGE_AW-1:0]   stage_addr;
    logic [ELEM_SEL_W-1:0] elem_sel;

    // selected taps
    logic                  tap_a_sel;
    logic                  tap_b_sel;

    // registered state and its next-state logic
    logic                  tap_reg_r;
    logic                  tap_b_reg_r;
    logic                  shift_pulse_r;
    logic [FILL_W-1:0]     fill_r;
    logic [FILL_W-1:0]     fill_nxt;
    logic [FILL_W-1:0]     fill_target;
    asr_fill_t             fill_state_r;
    asr_fill_t             fill_state_nxt;
    logic                  primed_r;

    asr_elem_if e_if [NUM_ELEM] ();

    asr_fifo #(
        .W     (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk    (i_ref_clk),
        .i_resetn (i_resetn),
        .i_valid  (i_in_valid),
        .o_ready  (fifo_in_ready),
        .i_data   (i_in_data),
        .o_valid  (fifo_valid),
        .i_ready  (ce_eff),
        .o_data   (fifo_data)
    );

    // clock enable: absent enable means always on
    assign ce_eff  = !i_ce_used || i_shift_ce;
    assign shift_w = fifo_valid && ce_eff;

    // address split into element select and stage
    assign stage_addr = i_tap_addr[STAGE_AW-1:0];
    assign elem_sel   = i_tap_addr[TAP_AW-1:STAGE_AW];

    genvar k;
    generate
        for (k = 0; k < NUM_ELEM; k++) begin : g_elem
            assign e_if[k].shift_en = shift_w;
            assign e_if[k].dual     = i_dual_mode;
            assign e_if[k].addr     = stage_addr;
            assign e_if[k].ser_b    = fifo_data[1];
            if (k == 0) begin : g_head
                assign e_if[k].ser_a = fifo_data[0];
            end else begin : g_link
                // cascade of previous element feeds this one; in dual mode fifo_data[0] does
                assign e_if[k].ser_a = i_dual_mode ? fifo_data[0] : last_vec[k-1];
            end
            assign tap_a_vec[k] = e_if[k].tap_a;
            assign tap_b_vec[k] = e_if[k].tap_b;
            assign last_vec[k]  = e_if[k].last;
            asr_elem u_elem (
                .i_clk    (i_ref_clk),
                .i_resetn (i_resetn),
                .e        (e_if[k])
            );
        end
    endgenerate

    // tap selection through the segment muxes
    assign tap_a_sel = seg_mux(tap_a_vec, elem_sel);
    assign tap_b_sel = seg_mux(tap_b_vec, elem_sel);

    // fill level tracking, saturating at chain length of 128, or at 16 in dual mode
    assign fill_target    = i_dual_mode ? FILL_HALF : FILL_FULL;
    assign fill_nxt       = (shift_w && fill_r < fill_target) ? fill_r + 1'b1 : fill_r;
    assign fill_state_nxt = next_fill_state(fill_state_r, fill_nxt, fill_target);

    function automatic asr_fill_t next_fill_state(
        input asr_fill_t         cur,
        input logic [FILL_W-1:0] lvl,
        input logic [FILL_W-1:0] tgt
    );
        asr_fill_t nxt;
        nxt = cur;
        case (cur)
            ASR_EMPTY: begin
                if (lvl != FILL_RST) begin
                    nxt = ASR_FILLING;
                end
            end
            ASR_FILLING: begin
                if (lvl >= tgt) begin
                    nxt = ASR_PRIMED;
                end
            end
            ASR_PRIMED: begin
                if (lvl < tgt) begin
                    nxt = ASR_FILLING;
                end
            end
            default: begin
                nxt = ASR_EMPTY;
            end
        endcase
        return nxt;
    endfunction

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tap_reg_r   <= 1'b0;
            tap_b_reg_r <= 1'b0;
        end else begin
            tap_reg_r   <= tap_a_sel;
            tap_b_reg_r <= tap_b_sel;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            shift_pulse_r <= 1'b0;
            fill_r        <= FILL_RST;
            fill_state_r  <= ASR_EMPTY;
            primed_r      <= 1'b0;
        end else begin
            shift_pulse_r <= shift_w;
            fill_r        <= fill_nxt;
            fill_state_r  <= fill_state_nxt;
            primed_r      <= (fill_state_nxt == ASR_PRIMED);
        end
    end

    // outputs; o_tap_out and o_tap_b_out are combinational by nature
    assign o_in_ready     = fifo_in_ready;
    assign o_tap_out      = tap_a_sel;
    assign o_tap_b_out    = tap_b_sel;
    assign o_tap_reg      = tap_reg_r;
    assign o_tap_b_reg    = tap_b_reg_r;
    assign o_cascade_out  = last_vec[NUM_ELEM-1];
    assign o_shift_pulse  = shift_pulse_r;
    assign o_chain_primed = primed_r;

    AST_STATIC_TAP: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (!shift_w ##1 $stable(i_tap_addr)) |-> $stable(o_tap_out))
        else $error("tap changed without shift or address change");

    AST_CASCADE_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        !shift_w |=> $stable(o_cascade_out))
        else $error("cascade output changed without a shift");

    AST_CHAIN_LINK: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (shift_w && !i_dual_mode && i_tap_addr == 7'h20) |=> o_tap_out == $past(last_vec[0])
            || !$stable(i_tap_addr) || i_dual_mode)
        else $error("chain link broken");

    AST_CASCADE_FROM_PREV: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (shift_w && !i_dual_mode) |=> o_cascade_out == $past(e_if[NUM_ELEM-1].tap_a)
            || $past(stage_addr) != 5'h1e)
        else $error("cascade did not take stage thirty");

    AST_CE_UNUSED: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (!i_ce_used && fifo_valid) |=> o_shift_pulse)
        else $error("no shift with enable unused");

    AST_REG_TAP: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        1'b1 |=> o_tap_reg == $past(o_tap_out))
        else $error("registered tap is not one cycle late");

    AST_ADDR_DELAY: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (shift_w && !i_dual_mode && i_tap_addr == 7'h00) |=> o_tap_out == $past(fifo_data[0])
            || !$stable(i_tap_addr) || i_dual_mode)
        else $error("address zero is not a one stage line");

    AST_PRIMED_FILL: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        o_chain_primed |-> fill_r >= fill_target || !$stable(i_dual_mode))
        else $error("primed flag without full chain");

    AST_CHAIN_LINK_TWO: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (shift_w && !i_dual_mode && i_tap_addr == 7'h40) |=> o_tap_out == $past(last_vec[1])
            || !$stable(i_tap_addr) || i_dual_mode)
        else $error("second chain link broken");

    AST_CHAIN_LINK_THREE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (shift_w && !i_dual_mode && i_tap_addr == 7'h60) |=> o_tap_out == $past(last_vec[2])
            || !$stable(i_tap_addr) || i_dual_mode)
        else $error("third chain link broken");

    AST_CE_STALL: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce_used && !i_shift_ce) |=> !o_shift_pulse)
        else $error("shift while enable low");

    AST_CE_SHIFT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce_used && i_shift_ce && fifo_valid) |=> o_shift_pulse)
        else $error("no shift with enable high");

    AST_TAP_B_IDLE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        !i_dual_mode |-> !o_tap_b_out)
        else $error("upper tap active outside split mode");

    AST_DUAL_SPLIT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (shift_w && i_dual_mode && i_tap_addr[3:0] == 4'h0)
            |=> o_tap_b_out == $past(fifo_data[1]) || !$stable(i_tap_addr) || !i_dual_mode)
        else $error("upper half did not start at its own input");

    AST_DUAL_NO_CHAIN: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (shift_w && i_dual_mode && i_tap_addr == 7'h20)
            |=> o_tap_out == $past(fifo_data[0]) || !$stable(i_tap_addr) || !i_dual_mode)
        else $error("split element took a chained input");

    AST_STALL_TAP: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        ((i_ce_used && !i_shift_ce) ##1 ($stable(i_tap_addr) && $stable(i_dual_mode)))
            |-> $stable(o_tap_out))
        else $error("tap moved during a stall");

    AST_PRIMED_RISE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        $rose(o_chain_primed) |-> $past(shift_w) || $past(i_dual_mode))
        else $error("primed without a shift");

    AST_DUAL_CASCADE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (shift_w && i_dual_mode && stage_addr[3:0] == 4'he)
            |=> o_cascade_out == $past(e_if[NUM_ELEM-1].tap_b) || !i_dual_mode)
        else $error("split cascade did not take stage thirty");

    AST_FILL_STEP: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (shift_w && fill_r < fill_target) |=> fill_r == $past(fill_r) + 8'h01)
        else $error("fill level missed a shift");

    AST_REG_TAP_B: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        1'b1 |=> o_tap_b_reg == $past(o_tap_b_out))
        else $error("registered upper tap is not one cycle late");

    AST_ADDR_LAST: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (!i_dual_mode && i_tap_addr == 7'h1f) |-> o_tap_out == last_vec[0])
        else $error("address thirty-one does not show the last stage");
endmodule

// *** verification/asr_user_model.sv ***
`timescale 1ns/1ns
module asr_user_model (
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_want,
    input  wire logic [1:0] i_word,
    input  wire logic       i_ready,
    output logic            o_valid,
    output logic [1:0]      o_data
);
    logic took;

    initial begin
        o_valid = 1'b0;
        o_data  = 2'h0;
        took    = 1'b0;
    end

    // accepted at this edge when offer meets ready
    always @(posedge i_clk) begin
        took <= o_valid && i_ready && i_resetn;
    end

    // offer held until taken; released data toggles every cycle
    always @(negedge i_clk) begin
        if (!i_resetn) begin
            o_valid <= 1'b0;
        end else if (!o_valid || took) begin
            o_valid <= i_want;
            o_data  <= i_want ? i_word : ~o_data;
        end
    end
endmodule

// *** verification/addressable_shift_register_tb.sv ***
`timescale 1ns/1ns
module addressable_shift_register_tb;
    import asr_pkg::*;
    logic              clk, rstn, want, ce_used, ce, dual, vld, rdy, sh, reg_ok, ptap, ptb;
    logic [1:0]        word, dat;
    logic [TAP_AW-1:0] addr;
    logic [TAP_AW-1:0] corner [8] = '{7'h00, 7'h1f, 7'h20, 7'h7f, 7'h40, 7'h60, 7'h1e, 7'h0f};
    logic              m [CHAIN_STAGES];
    logic [1:0]        q [$];
    logic [31:0]       r;
    int                failures, samples_checked, fill, cnt, mode;
    int                seed = 32'h9768;
    wire logic         valid, in_ready, tap, tap_b, tap_reg, tap_b_reg, casc, pulse, primed;
    wire logic [1:0]   data;

    asr_top i_dut (
        .i_ref_clk(clk), .i_resetn(rstn), .i_in_valid(valid), .i_in_data(data),
        .i_ce_used(ce_used), .i_shift_ce(ce), .i_dual_mode(dual), .i_tap_addr(addr),
        .o_in_ready(in_ready), .o_tap_out(tap), .o_tap_b_out(tap_b), .o_tap_reg(tap_reg),
        .o_tap_b_reg(tap_b_reg), .o_cascade_out(casc), .o_shift_pulse(pulse),
        .o_chain_primed(primed)
    );
    asr_user_model i_user (
        .i_clk(clk), .i_resetn(rstn), .i_want(want), .i_word(word),
        .i_ready(in_ready), .o_valid(valid), .o_data(data)
    );

    function automatic int thr();
        return dual ? HALF_STAGES : CHAIN_STAGES;
    endfunction

    // expected tap: dual splits into lower and upper halves of 16
    function automatic logic etap(input logic [TAP_AW-1:0] a, input logic upper);
        if (dual) return m[(upper ? 16 : 0) + int'(a[3:0])];
        return upper ? 1'b0 : m[a];
    endfunction

    task automatic push_in(input logic [1:0] d);
        for (int i = CHAIN_STAGES - 1; i > 0; i--) m[i] = (dual && i == 16) ? d[1] : m[i-1];
        m[0] = d[0];
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (failures == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // reference chain and buffer, updated at every rising edge
    always @(posedge clk) begin
        if (!rstn) begin
            q.delete();
            cnt    = 0;
            sh     = 1'b0;
            reg_ok = 1'b0;
        end else begin
            ptap   = etap(addr, 1'b0);
            ptb    = etap(addr, 1'b1);
            reg_ok = fill >= thr();
            sh     = q.size() > 0 && (!ce_used || ce);
            if (sh) begin
                push_in(q.pop_front());
                cnt++;
                fill++;
            end
            if (vld && rdy) q.push_back(dat);
        end
    end

    always @(negedge clk) begin
        r       = $random(seed);
        word    = r[1:0];
        want    = (mode == 2) ? 1'b0 : ((mode == 1) ? 1'b1 : (r[2] | r[3]));
        ce_used = (mode == 0) ? r[4] : 1'b1;
        ce      = (mode == 1) ? 1'b0 : ((mode == 2) ? 1'b1 : (r[5] | r[6]));
        if (r[7]) addr = (r[9:8] == 2'h0) ? corner[r[12:10]] : r[18:12];
        #1;
        rdy = in_ready;
        vld = valid;
        dat = data;
        if (rstn) begin
            check(in_ready, q.size() < FIFO_DEPTH);
            check(pulse, sh);
            check(primed, cnt >= thr());
            if (!dual) check(tap_b, 1'b0);
            if (fill >= thr()) begin
                check(tap, etap(addr, 1'b0));
                check(tap_b, etap(addr, 1'b1));
                check(casc, dual ? m[31] : m[CHAIN_STAGES-1]);
            end
            if (reg_ok) check(tap_reg, ptap);
            if (reg_ok) check(tap_b_reg, ptb);
        end
    end

    initial begin
        {rstn, want, ce_used, ce, dual, word, addr} = '0;
        {failures, samples_checked, fill, cnt, mode} = '0;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        repeat (250) @(negedge clk);
        mode = 1;
        repeat (24) @(negedge clk);
        mode = 2;
        repeat (30) @(negedge clk);
        mode = 0;
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        repeat (100) @(negedge clk);
        rstn = 1'b0;
        dual = 1'b1;
        fill = 0;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        repeat (300) @(negedge clk);
        results();
    end

    // about 720 cycles expected
    initial begin
        #(2000 * 50);
        failures++;
        results();
    end
endmodule
